//--- design/smf_defines.vh
// Constants for the supply monitor filter block.
// Assumes inclusion by bare name from the design file.
`ifndef SMF_DEFINES_VH
`define SMF_DEFINES_VH
`define SMF_NCH 12
`define SMF_MV_W 13
`define SMF_RANGE_W 4
`define SMF_REF_W 6
`define SMF_REF_STEPS 19'h0001F
`define SMF_REF_NEAR_GND 6'h20
`define SMF_NEAR_GND_MV 13'h0050
`define SMF_SAMPLE_DIV 2'h3
`define SMF_FILT_MAX 3'h7
`define SMF_FILT_MIN 3'h0
`define SMF_NDIN 4
`endif

//--- design/smf_supply_monitor_filter.v
// Twelve supply monitor channels: threshold comparator with hysteresis outside near-ground mode,
// sampling synchronizer and optional saturating glitch filter.
// Assumes monitored voltages arrive as millivolt codes synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "smf_defines.vh"

module smf_supply_monitor_filter (
	input wire sys_clk,
	input wire nrst,
	input wire clk_en,
	input wire [`SMF_NCH*`SMF_MV_W-1:0] vmon_mv,
	input wire [`SMF_NCH*`SMF_RANGE_W-1:0] range_sel,
	input wire [`SMF_NCH*`SMF_REF_W-1:0] ref_sel,
	input wire [`SMF_NCH-1:0] filt_en,
	input wire [`SMF_NDIN-1:0] din,
	output wire [`SMF_NCH-1:0] cmp_raw,
	output wire [`SMF_NCH-1:0] mon_out,
	output wire sample_stb,
	output wire [2*`SMF_NCH+`SMF_NDIN-`SMF_NCH-1:0] seq_in
);

	// ------------------------------------------------------------
	// Threshold lookup
	// ------------------------------------------------------------
	// Low and high end of each coarse range in mV
	function [`SMF_MV_W-1:0] range_lo;
		input [`SMF_RANGE_W-1:0] r;
		begin
			case (r)
				4'h0: range_lo = 13'h02A8;
				4'h1: range_lo = 13'h0328;
				4'h2: range_lo = 13'h03C2;
				4'h3: range_lo = 13'h0476;
				4'h4: range_lo = 13'h0553;
				4'h5: range_lo = 13'h0652;
				4'h6: range_lo = 13'h078B;
				4'h7: range_lo = 13'h08F1;
				4'h8: range_lo = 13'h0AA4;
				4'h9: range_lo = 13'h0CA9;
				4'hA: range_lo = 13'h107D;
				default: range_lo = 13'h1399;
			endcase
		end
	endfunction

	function [`SMF_MV_W-1:0] range_hi;
		input [`SMF_RANGE_W-1:0] r;
		begin
			case (r)
				4'h0: range_hi = 13'h0323;
				4'h1: range_hi = 13'h03BA;
				4'h2: range_hi = 13'h0471;
				4'h3: range_hi = 13'h0546;
				4'h4: range_hi = 13'h064A;
				4'h5: range_hi = 13'h0779;
				4'h6: range_hi = 13'h08EA;
				4'h7: range_hi = 13'h0A92;
				4'h8: range_hi = 13'h0C95;
				4'h9: range_hi = 13'h0EF9;
				4'hA: range_hi = 13'h137E;
				default: range_hi = 13'h172C;
			endcase
		end
	endfunction

	// Hysteresis in mV per range
	function [`SMF_MV_W-1:0] range_hyst;
		input [`SMF_RANGE_W-1:0] r;
		begin
			case (r)
				4'h0: range_hyst = 13'h0004;
				4'h1: range_hyst = 13'h0005;
				4'h2: range_hyst = 13'h0006;
				4'h3: range_hyst = 13'h0007;
				4'h4: range_hyst = 13'h0008;
				4'h5: range_hyst = 13'h000A;
				4'h6: range_hyst = 13'h000C;
				4'h7: range_hyst = 13'h000E;
				4'h8: range_hyst = 13'h0010;
				4'h9: range_hyst = 13'h0013;
				4'hA: range_hyst = 13'h0019;
				default: range_hyst = 13'h001E;
			endcase
		end
	endfunction

	// Fine steps are interpolated linearly; error stays under one step.
	function [`SMF_MV_W-1:0] trip_mv;
		input [`SMF_RANGE_W-1:0] r;
		input [`SMF_REF_W-1:0] s;
		reg [`SMF_MV_W+5:0] span;
		begin
			span = 19'h00000;
			if (s[5]) begin
				trip_mv = `SMF_NEAR_GND_MV;
			end else begin
				span = {6'h00, range_hi(r) - range_lo(r)} * {13'h0000, s};
				// Quotient never exceeds the range span, so the cut is safe
				span = span / `SMF_REF_STEPS;
				trip_mv = range_lo(r) + span[`SMF_MV_W-1:0];
			end
		end
	endfunction

	// Next count of one saturating filter counter
	function [2:0] filt_step;
		input up;
		input [2:0] c;
		begin
			filt_step = c;
			if (up && c != `SMF_FILT_MAX) begin
				filt_step = c + 3'h1;
			end else if (!up && c != `SMF_FILT_MIN) begin
				filt_step = c - 3'h1;
			end
		end
	endfunction

	// Filter level: set at full count, cleared at empty, else held
	function filt_level;
		input [2:0] c;
		input prev;
		begin
			if (c == `SMF_FILT_MAX) begin
				filt_level = 1'b1;
			end else if (c == `SMF_FILT_MIN) begin
				filt_level = 1'b0;
			end else begin
				filt_level = prev;
			end
		end
	endfunction

	// ------------------------------------------------------------
	// Sample strobe
	// ------------------------------------------------------------
	reg [1:0] div_q;
	wire stb = (div_q == `SMF_SAMPLE_DIV);

	always @(posedge sys_clk) begin
		if (!nrst) begin
			div_q <= 2'h0;
		end else if (clk_en) begin
			div_q <= div_q + 2'h1;
		end
	end

	assign sample_stb = stb & clk_en;

	// ------------------------------------------------------------
	// Channels
	// ------------------------------------------------------------
	reg [`SMF_NCH-1:0] cmp_q;
	reg [`SMF_NCH-1:0] sync_q;
	reg [`SMF_NCH-1:0] filt_q;
	reg [`SMF_NCH-1:0] out_q;
	reg [2:0] cnt_q [0:`SMF_NCH-1];
	reg [`SMF_NDIN-1:0] din_q;
	wire [`SMF_NCH-1:0] cmp_d;
	wire [`SMF_NCH-1:0] filt_d;
	wire [`SMF_NCH-1:0] out_d;
	wire [3*`SMF_NCH-1:0] cnt_d;
	integer i;
	genvar g;

	generate
		for (g = 0; g < `SMF_NCH; g = g + 1) begin : g_ch
			wire [`SMF_RANGE_W-1:0] rng_w;
			wire [`SMF_REF_W-1:0] ref_w;
			wire [`SMF_MV_W-1:0] v_w;
			wire [`SMF_MV_W-1:0] trip_w;
			wire [`SMF_MV_W-1:0] hyst_w;
			assign rng_w = range_sel[g*`SMF_RANGE_W +: `SMF_RANGE_W];
			assign ref_w = ref_sel[g*`SMF_REF_W +: `SMF_REF_W];
			assign v_w = vmon_mv[g*`SMF_MV_W +: `SMF_MV_W];
			assign trip_w = trip_mv(rng_w, ref_w);
			// Near-ground detect works without hysteresis
			assign hyst_w = ref_w[`SMF_REF_W-1] ? 13'h0000 : range_hyst(rng_w);
			// compare with hysteresis; inside the band the state holds
			assign cmp_d[g] = (v_w >= trip_w) ? 1'b1 :
				(v_w < trip_w - hyst_w) ? 1'b0 : cmp_q[g];
			// saturating counter fed by the synchronizer
			assign cnt_d[3*g +: 3] = filt_step(sync_q[g], cnt_q[g]);
			// set and clear at the ends only
			assign filt_d[g] = filt_level(cnt_d[3*g +: 3], filt_q[g]);
			// per-channel bypass of the counter
			// Bypass takes what the synchronizer captures, saving one sample period
			assign out_d[g] = filt_en[g] ? filt_d[g] : cmp_q[g];
		end
	endgenerate

	// synchronizer and filter advance on sample strobes only
	always @(posedge sys_clk) begin
		if (!nrst) begin
			cmp_q <= {`SMF_NCH{1'b0}};
			sync_q <= {`SMF_NCH{1'b0}};
			filt_q <= {`SMF_NCH{1'b0}};
			out_q <= {`SMF_NCH{1'b0}};
			din_q <= {`SMF_NDIN{1'b0}};
			for (i = 0; i < `SMF_NCH; i = i + 1) begin
				cnt_q[i] <= `SMF_FILT_MIN;
			end
		end else if (clk_en) begin
			din_q <= din;
			cmp_q <= cmp_d;
			if (stb) begin
				sync_q <= cmp_q;
				filt_q <= filt_d;
				out_q <= out_d;
				for (i = 0; i < `SMF_NCH; i = i + 1) begin
					cnt_q[i] <= cnt_d[3*i +: 3];
				end
			end
		end
	end

	assign cmp_raw = cmp_q;
	assign mon_out = out_q;
	assign seq_in = {din_q, out_q};

endmodule // smf_supply_monitor_filter

`default_nettype wire

//--- tb/smf_seq_model.sv
// Sequencer stand-in that registers the sixteen flags it receives.
// Assumes it shares the monitor block clock.
`timescale 1ns/1ps
`default_nettype none
module smf_seq_model (
	input wire logic sys_clk,
	input wire logic [15:0] seq_in,
	output wire logic [15:0] seq_flags
);
	logic [15:0] flags_q;
	always @(posedge sys_clk) begin
		flags_q <= seq_in;
	end
	assign seq_flags = flags_q;
endmodule // smf_seq_model
`default_nettype wire

//--- tb/smf_props.sv
// Port checker for the supply monitor block.
// Assumes it is bound into the block and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module smf_props (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic [3:0] din,
	input wire logic [155:0] vmon_mv,
	input wire logic [47:0] range_sel,
	input wire logic [71:0] ref_sel,
	input wire logic [11:0] filt_en,
	input wire logic [11:0] cmp_raw,
	input wire logic [11:0] mon_out,
	input wire logic sample_stb,
	input wire logic [15:0] seq_in
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// A pause of clk_en stretches the spacing, so it aborts the check
	stb_space_a: assert property (disable iff (!nrst || !clk_en)
		sample_stb |=> !sample_stb [*3] ##1 sample_stb) else $error("strobe spacing");
	freeze_hold_a: assert property (!clk_en |=>
		$stable(cmp_raw) && $stable(mon_out) && $stable(seq_in)) else $error("freeze");
	mon_hold_a: assert property (!$stable(mon_out) |-> $past(sample_stb))
		else $error("result moved off strobe");
	bypass_pass_a: assert property (sample_stb |=>
		((mon_out ^ $past(cmp_raw)) & ~$past(filt_en)) == 12'h000) else $error("bypass");
	seq_mon_a: assert property (seq_in[11:0] == mon_out)
		else $error("sequencer flags");
	seq_din_a: assert property ($past(nrst && clk_en) |-> seq_in[15:12] == $past(din))
		else $error("sequencer pins");
	near_gnd_a: assert property ($past(nrst && clk_en && ref_sel[5]) |->
		cmp_raw[0] == ($past(vmon_mv[12:0]) >= 13'h0050)) else $error("near ground");
	top_rise_a: assert property ($past(nrst && clk_en && ref_sel[11:6] == 6'h00 &&
		range_sel[7:4] == 4'hB && vmon_mv[25:13] >= 13'h1399) |-> cmp_raw[1]) else $error("rise");
	top_fall_a: assert property ($past(nrst && clk_en && ref_sel[11:6] == 6'h00 &&
		range_sel[7:4] == 4'hB && vmon_mv[25:13] < 13'h137B) |-> !cmp_raw[1]) else $error("fall");
endmodule // smf_props
bind smf_supply_monitor_filter smf_props u_props(.sys_clk(sys_clk), .nrst(nrst),
	.clk_en(clk_en), .din(din),
	.vmon_mv(vmon_mv), .range_sel(range_sel), .ref_sel(ref_sel), .filt_en(filt_en),
	.cmp_raw(cmp_raw), .mon_out(mon_out), .sample_stb(sample_stb), .seq_in(seq_in));
`default_nettype wire

//--- tb/testbench.sv
// Testbench: ch0 filtered near-ground, ch1 bypassed top range.
// Assumes inputs change on the falling edge only.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic clk_en = 1'b1;
	wire [15:0] seq_flags;
	logic [3:0] din = 4'h0;
	logic [11:0] filt_en = 12'h001;
	logic [155:0] vmon_mv = '0;
	logic [47:0] range_sel = {12{4'hB}};
	logic [71:0] ref_sel = {{11{6'h00}}, 6'h20};
	wire [11:0] cmp_raw;
	wire [11:0] mon_out;
	wire [15:0] seq_in;
	int n_errors = 0;
	int n_compared = 0;
	always #12.5 sys_clk = ~sys_clk;
	smf_supply_monitor_filter u_smf_supply_monitor_filter(.sys_clk(sys_clk), .nrst(nrst),
		.clk_en(clk_en), .vmon_mv(vmon_mv), .range_sel(range_sel), .ref_sel(ref_sel),
		.filt_en(filt_en), .din(din), .cmp_raw(cmp_raw), .mon_out(mon_out),
		.sample_stb(), .seq_in(seq_in));
	smf_seq_model u_smf_seq_model(.sys_clk(sys_clk), .seq_in(seq_in), .seq_flags(seq_flags));
	task report_and_stop;
		$display("compared=%0d errors=%0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Bounded wait for one monitor result
	task wt(input int i, input logic v, input int lim, output int n);
		n = 0;
		while (mon_out[i] !== v) begin
			@(negedge sys_clk);
			n++;
			if (n > lim) begin
				n_errors++;
				report_and_stop();
			end
		end
	endtask
	task t_bypass;
		int n;
		din = 4'hA;
		vmon_mv[25:13] = 13'h13B0;
		wt(1, 1'b1, 8, n);
		chk({15'h0, n <= 5}, 16'h0001);
		chk({4'h0, mon_out}, 16'h0002);
		chk(seq_in, 16'hA002);
		vmon_mv[25:13] = 13'h1388;
		repeat (8) @(negedge sys_clk);
		chk({4'h0, mon_out}, 16'h0002);
		vmon_mv[25:13] = 13'h1370;
		wt(1, 1'b0, 8, n);
		chk({15'h0, n <= 5}, 16'h0001);
		$display("test bypass done");
	endtask
	task t_filter;
		int n;
		vmon_mv[12:0] = 13'h00C8;
		repeat (3) @(negedge sys_clk);
		vmon_mv[12:0] = 13'h0010;
		repeat (40) @(negedge sys_clk);
		chk({4'h0, mon_out}, 16'h0000);
		vmon_mv[12:0] = 13'h00C8;
		wt(0, 1'b1, 40, n);
		chk({15'h0, n >= 29 && n <= 37}, 16'h0001);
		vmon_mv[12:0] = 13'h0010;
		wt(0, 1'b0, 40, n);
		chk({15'h0, n >= 29 && n <= 37}, 16'h0001);
		$display("test filter done");
	endtask
	// Clock enable low must freeze every flag and the strobe phase
	task t_freeze;
		int n;
		clk_en = 1'b0;
		din = 4'h5;
		vmon_mv[25:13] = 13'h13B0;
		repeat (12) @(negedge sys_clk);
		chk({4'h0, cmp_raw}, 16'h0000);
		chk(seq_in, 16'hA000);
		clk_en = 1'b1;
		wt(1, 1'b1, 8, n);
		chk({15'h0, n <= 5}, 16'h0001);
		chk(seq_in, 16'h5002);
		@(negedge sys_clk);
		chk(seq_flags, 16'h5002);
		$display("test freeze done");
	endtask
	// Mid-run reset clears all, first strobe at the fourth edge after release
	task t_reset;
		int n;
		nrst = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk({4'h0, cmp_raw}, 16'h0000);
		chk({4'h0, mon_out}, 16'h0000);
		chk(seq_in, 16'h0000);
		nrst = 1'b1;
		wt(1, 1'b1, 8, n);
		chk(n[15:0], 16'h0004);
		$display("test reset done");
	endtask
	initial begin
		repeat (2) @(negedge sys_clk);
		nrst = 1'b1;
		t_bypass();
		t_filter();
		t_freeze();
		t_reset();
		report_and_stop();
	end
endmodule // testbench
`default_nettype wire
